//--- shared/jis_pkg.sv
// shared constants and types for the debug instruction and chain select block
package jis_pkg;
	// instruction register width and capture pattern
	localparam int IR_W = 4;
	localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;
	// instruction codes
	localparam logic [IR_W-1:0] INSTR_EXT_TEST = 4'h0;
	localparam logic [IR_W-1:0] INSTR_CHAIN_SEL = 4'h2;
	localparam logic [IR_W-1:0] INSTR_INT_TEST = 4'hc;
	localparam logic [IR_W-1:0] INSTR_IDENT = 4'he;
	localparam logic [IR_W-1:0] INSTR_BYPASS = 4'hf;
	// scan path select register width, capture pattern and reset chain
	localparam int SEL_W = 5;
	localparam logic [SEL_W-1:0] SEL_CAPTURE_VAL = 5'h10;
	localparam logic [SEL_W-1:0] SEL_RESET_CHAIN = 5'h03;
	// identification register width
	localparam int ID_W = 32;
	// selection buffer depth
	localparam int BUF_DEPTH = 2;
	// bit positions inside the synchroniser bundle
	localparam int SY_TCK = 0;
	localparam int SY_TMS = 1;
	localparam int SY_TDI = 2;
	localparam int SY_CAP_DR = 3;
	localparam int SY_SHIFT_DR = 4;
	localparam int SY_UPD_DR = 5;
	localparam int SY_CAP_IR = 6;
	localparam int SY_SHIFT_IR = 7;
	localparam int SY_UPD_IR = 8;
	localparam int SY_RESET = 9;
	localparam int SY_CTRL_W = 10;
	localparam int SY_W = SY_CTRL_W + ID_W;
	// data path placed between serial in and serial out
	typedef enum logic [1:0] {PATH_BYPASS, PATH_IDENT, PATH_SELECT, PATH_CHAIN} jis_path_t;
endpackage

//--- shared/jis_stream_if.sv
// valid/ready stream carrying chain numbers between the block's modules
`timescale 1ns/10ps
interface jis_stream_if;
	import jis_pkg::*;
	logic valid; // word offered
	logic ready; // word can be taken
	logic [SEL_W-1:0] data; // chain number
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

//--- hdl/jis_pair_buf.sv
// two-entry buffer for chain selection words
`timescale 1ns/10ps
module jis_pair_buf
(
	input wire logic core_clk,
	input wire logic nrst,
	jis_stream_if.snk inPort,
	jis_stream_if.src outPort
);
	import jis_pkg::*;

	logic [SEL_W-1:0] mem_q [BUF_DEPTH]; // storage
	logic wrPtr_q; // next slot written
	logic rdPtr_q; // next slot read
	logic [1:0] count_q; // words held
	wire push = inPort.valid & inPort.ready;
	wire pop = outPort.valid & outPort.ready;

	// full and empty straight from the count
	assign inPort.ready = (count_q != 2'(BUF_DEPTH));
	assign outPort.valid = (count_q != 2'h0);
	assign outPort.data = mem_q[rdPtr_q];

	// pointers and count
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wrPtr_q <= 1'b0;
			rdPtr_q <= 1'b0;
			count_q <= 2'h0;
		end
		else
		begin
			if (push)
				wrPtr_q <= ~wrPtr_q;
			if (pop)
				rdPtr_q <= ~rdPtr_q;
			count_q <= count_q + 2'(push) - 2'(pop);
		end
	end

	// storage writes
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
		end
		else if (push)
			mem_q[wrPtr_q] <= inPort.data;
	end
endmodule

//--- hdl/jis_chain_select.sv
// instruction decode, scan path select and serial data paths of the debug port
// Contract
// - sample serial in and mode on rising clock
// - serial out changes only on falling clock
// - code 0000 puts selected chain under test
// - external test capture takes system inputs, outputs
// - external test shift applies bits immediately
// - code 0010 routes the select register
// - select register captures 0b10000
// - update makes chosen chain active, persistent
// - chain 3 selected after reset
// - select register is five bits
// - code 1100 puts selected chain under test
// - internal test capture takes core, system values
// - internal test shift moves bits through
// - 1111 and unknown codes act as bypass
// - bypass register captures zero
// - code 1110 routes identification; reset selects it
// - four-bit instruction captures 0b0001, no parity
`timescale 1ns/10ps
module jis_chain_select
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tapCaptureDr,
	input wire logic tapShiftDr,
	input wire logic tapUpdateDr,
	input wire logic tapCaptureIr,
	input wire logic tapShiftIr,
	input wire logic tapUpdateIr,
	input wire logic tapLogicReset,
	input wire logic [jis_pkg::ID_W-1:0] tapId,
	output logic tdo,
	output logic tdoEn,
	output logic tmsSampled,
	output logic [jis_pkg::IR_W-1:0] activeInstr,
	output logic [jis_pkg::SEL_W-1:0] chainSel,
	output logic chainTestMode,
	output logic chainIntTest,
	output logic chainApplyNow,
	output logic chainCapture,
	output logic chainShift,
	output logic chainShiftIn,
	input wire logic chainShiftOut,
	output logic selValid,
	output logic [jis_pkg::SEL_W-1:0] selData,
	input wire logic selReady
);
	import jis_pkg::*;

	// synchroniser stages for every pin input
	logic [SY_W-1:0] syncA_q; // first stage, read only by the second
	logic [SY_W-1:0] syncB_q; // second stage, safe to use
	logic tckPrev_q; // last synced clock level

	// serial registers
	logic [IR_W-1:0] irShift_q; // instruction shift stage
	logic [IR_W-1:0] ir_q; // current instruction
	logic [SEL_W-1:0] selShift_q; // select shift stage
	logic [SEL_W-1:0] chainSel_q; // active chain number
	logic [ID_W-1:0] idShift_q; // identification shift stage
	logic bypass_q; // one-bit bypass stage

	// pin side outputs
	logic tdo_q; // serial out bit
	logic tdoEn_q; // serial out driven
	logic tms_q; // last sampled mode bit
	logic capPulse_q; // chain capture strobe
	logic shiftPulse_q; // chain shift strobe
	logic shiftIn_q; // bit passed to the chain
	logic pend_q; // selection waiting for the buffer

	// stream from the select logic into the buffer, and out of it
	jis_stream_if selIn ();
	jis_stream_if selOut ();

	// synced pin views
	wire tckS = syncB_q[SY_TCK];
	wire tmsS = syncB_q[SY_TMS];
	wire tdiS = syncB_q[SY_TDI];
	wire capDr = syncB_q[SY_CAP_DR];
	wire shDr = syncB_q[SY_SHIFT_DR];
	wire updDr = syncB_q[SY_UPD_DR];
	wire capIr = syncB_q[SY_CAP_IR];
	wire shIr = syncB_q[SY_SHIFT_IR];
	wire updIr = syncB_q[SY_UPD_IR];
	wire tlr = syncB_q[SY_RESET];
	wire [ID_W-1:0] idS = syncB_q[SY_W-1:SY_CTRL_W];

	// clock edges seen on the core clock
	wire tckRise = tckS & ~tckPrev_q;
	wire tckFall = ~tckS & tckPrev_q;

	// instruction decode
	wire isExt = (ir_q == INSTR_EXT_TEST);
	wire isInt = (ir_q == INSTR_INT_TEST);
	wire isSel = (ir_q == INSTR_CHAIN_SEL);
	wire isId = (ir_q == INSTR_IDENT);
	// test instructions route the chain, unknown codes fall to bypass
	wire jis_path_t path = (isExt | isInt) ? PATH_CHAIN :
		isSel ? PATH_SELECT :
		isId ? PATH_IDENT :
		PATH_BYPASS;
	wire onChain = (path == PATH_CHAIN);

	// data register bit presented on serial out
	wire drOut = (path == PATH_CHAIN) ? chainShiftOut :
		(path == PATH_SELECT) ? selShift_q[0] :
		(path == PATH_IDENT) ? idShift_q[0] :
		bypass_q;
	// instruction bit wins while the instruction path shifts
	wire serialOut = shIr ? irShift_q[0] : drOut;

	// rising-edge actions
	wire riseCapIr = tckRise & capIr;
	wire riseShIr = tckRise & shIr;
	wire riseUpdIr = tckRise & updIr;
	wire riseCapDr = tckRise & capDr;
	wire riseShDr = tckRise & shDr;
	wire riseUpdDr = tckRise & updDr;
	wire newChain = riseUpdDr & (path == PATH_SELECT);

	// two-flop synchroniser, stage a feeds stage b only
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			syncA_q <= '0;
			syncB_q <= '0;
			tckPrev_q <= 1'b0;
		end
		else
		begin
			syncA_q <= {tapId, tapLogicReset, tapUpdateIr, tapShiftIr, tapCaptureIr,
				tapUpdateDr, tapShiftDr, tapCaptureDr, tdi, tms, tck};
			syncB_q <= syncA_q;
			tckPrev_q <= tckS;
		end
	end

	// mode bit taken on the rising edge for the state machine
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			tms_q <= 1'b0;
		else if (tckRise)
			tms_q <= tmsS;
	end

	// instruction shift stage: fixed capture, lsb out first
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			irShift_q <= IR_CAPTURE_VAL;
		else if (riseCapIr)
			irShift_q <= IR_CAPTURE_VAL;
		else if (riseShIr)
			irShift_q <= {tdiS, irShift_q[IR_W-1:1]};
	end

	// current instruction: only update or reset changes it
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			ir_q <= INSTR_IDENT;
		else if (tlr)
			ir_q <= INSTR_IDENT;
		else if (riseUpdIr)
			ir_q <= irShift_q;
	end

	// select shift stage: fixed capture, chain number shifted in by the probe
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			selShift_q <= SEL_CAPTURE_VAL;
		else if (riseCapDr & (path == PATH_SELECT))
			selShift_q <= SEL_CAPTURE_VAL;
		else if (riseShDr & (path == PATH_SELECT))
			selShift_q <= {tdiS, selShift_q[SEL_W-1:1]};
	end

	// active chain: changes only at update under chain select
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			chainSel_q <= SEL_RESET_CHAIN;
		else if (newChain)
			chainSel_q <= selShift_q;
	end

	// identification stage loads the tied word at capture
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			idShift_q <= '0;
		else if (riseCapDr & (path == PATH_IDENT))
			idShift_q <= idS;
		else if (riseShDr & (path == PATH_IDENT))
			idShift_q <= {tdiS, idShift_q[ID_W-1:1]};
	end

	// bypass stage captures zero, then passes serial in
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			bypass_q <= 1'b0;
		else if (riseCapDr & (path == PATH_BYPASS))
			bypass_q <= 1'b0;
		else if (riseShDr & (path == PATH_BYPASS))
			bypass_q <= tdiS;
	end

	// strobes to the selected chain: capture and shift for one core cycle
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			capPulse_q <= 1'b0;
			shiftPulse_q <= 1'b0;
			shiftIn_q <= 1'b0;
		end
		else
		begin
			capPulse_q <= riseCapDr & onChain;
			shiftPulse_q <= riseShDr & onChain;
			if (riseShDr & onChain)
				shiftIn_q <= tdiS;
		end
	end

	// serial out moves only on the falling edge
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tdo_q <= 1'b0;
			tdoEn_q <= 1'b0;
		end
		else if (tckFall)
		begin
			tdo_q <= serialOut;
			tdoEn_q <= shIr | shDr;
		end
	end

	// new chain number waits here until the buffer takes it; set beats clear
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			pend_q <= 1'b0;
		else if (newChain)
			pend_q <= 1'b1;
		else if (selIn.ready)
			pend_q <= 1'b0;
	end

	// offer the active chain number to the buffer
	assign selIn.valid = pend_q;
	assign selIn.data = chainSel_q;
	assign selOut.ready = selReady;

	// buffer toward the chain fabric; while it is full, a newer update replaces the word still waiting in chainSel_q
	jis_pair_buf uBuf
	(
		.core_clk(core_clk),
		.nrst(nrst),
		.inPort(selIn),
		.outPort(selOut)
	);

	// outputs
	assign tdo = tdo_q;
	assign tdoEn = tdoEn_q;
	assign tmsSampled = tms_q;
	assign activeInstr = ir_q;
	assign chainSel = chainSel_q;
	assign chainTestMode = onChain;
	assign chainIntTest = isInt;
	assign chainApplyNow = isExt & shDr;
	assign chainCapture = capPulse_q;
	assign chainShift = shiftPulse_q;
	assign chainShiftIn = shiftIn_q;
	assign selValid = selOut.valid;
	assign selData = selOut.data;
endmodule

//--- testbench/jis_checker.sv
// port assertions for the chain select block
`timescale 1ns/10ps
module jis_checker
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic tck,
	input wire logic tdo,
	input wire logic tdoEn,
	input wire logic tapUpdateDr,
	input wire logic [jis_pkg::IR_W-1:0] activeInstr,
	input wire logic [jis_pkg::SEL_W-1:0] chainSel,
	input wire logic chainTestMode,
	input wire logic chainIntTest,
	input wire logic chainApplyNow,
	input wire logic chainCapture,
	input wire logic chainShift,
	input wire logic selValid,
	input wire logic [jis_pkg::SEL_W-1:0] selData,
	input wire logic selReady
);
	import jis_pkg::*;
	logic [3:0] drAge_q; // cycles since the data update level
	// age counter, saturating
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
			drAge_q <= 4'hf;
		else
			drAge_q <= tapUpdateDr ? 4'h0 : drAge_q + {3'h0, drAge_q != 4'hf};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	property p_tdoFall; $changed(tdo) |-> !$past(tck, 2); endproperty
	a_tdoFall: assert property (p_tdoFall) else $error("tdo moved off a fall");
	property p_selStable; $changed(chainSel) |-> drAge_q < 4'h4; endproperty
	a_selStable: assert property (p_selStable) else $error("chain moved off update");
	property p_testMode;
		chainTestMode == (activeInstr == INSTR_EXT_TEST || activeInstr == INSTR_INT_TEST);
	endproperty
	a_testMode: assert property (p_testMode) else $error("test mode wrong");
	property p_intTest; chainTestMode |-> chainIntTest == (activeInstr == INSTR_INT_TEST); endproperty
	a_intTest: assert property (p_intTest) else $error("capture source wrong");
	property p_applyNow; chainApplyNow |-> activeInstr == INSTR_EXT_TEST; endproperty
	a_applyNow: assert property (p_applyNow) else $error("apply outside ext test");
	property p_shiftPulse; chainShift |=> !chainShift; endproperty
	a_shiftPulse: assert property (p_shiftPulse) else $error("shift strobe too long");
	property p_shiftOnlyTest; chainShift |-> chainTestMode; endproperty
	a_shiftOnlyTest: assert property (p_shiftOnlyTest) else $error("chain shifted");
	property p_selHold; selValid && !selReady |=> selValid && $stable(selData); endproperty
	a_selHold: assert property (p_selHold) else $error("word lost in stall");
	// capture strobe only under a test instruction, one cycle long
	property p_capPulse; chainCapture |-> chainTestMode ##1 !chainCapture; endproperty
	a_capPulse: assert property (p_capPulse) else $error("capture strobe wrong");
	// external test shift must reach the system at once
	property p_applyShift; chainShift && activeInstr == INSTR_EXT_TEST |-> chainApplyNow; endproperty
	a_applyShift: assert property (p_applyShift) else $error("ext shift not applied");
	// serial out is driven while the chain shifts
	property p_shiftEn; chainShift |-> tdoEn; endproperty
	a_shiftEn: assert property (p_shiftEn) else $error("tdo not driven in shift");
endmodule

//--- testbench/jis_probe.sv
// model of the external debug probe
`timescale 1ns/10ps
module jis_probe
(
	input wire logic core_clk,
	input wire logic tdo,
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic [6:0] st
);
	// idle levels, clock low
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		st = 7'h0;
	end
	// one clock period: levels set while low, tdo taken after the rise
	task automatic step(input logic [6:0] s, input logic d, output logic q);
		tck <= 1'b0;
		st <= s;
		tdi <= d;
		tms <= ~d;
		repeat (4) @(posedge core_clk);
		tck <= 1'b1;
		@(posedge core_clk);
		q = tdo;
		repeat (3) @(posedge core_clk);
	endtask
	// capture, n shifts lsb first, update, idle; b 0 data, 3 instruction
	task automatic scan(input int b, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		dout = '0;
		step(7'h1 << b, 1'b0, q);
		for (int i = 0; i < n; i++)
		begin
			step(7'h2 << b, din[i], q);
			dout[i] = q;
		end
		step(7'h4 << b, 1'b0, q);
		step(7'h0, 1'b1, q);
	endtask
endmodule

//--- testbench/tb_jis_chain_select.sv
// testbench for the chain select block
`timescale 1ns/10ps
module tb_jis_chain_select;
	import jis_pkg::*;
	localparam logic [ID_W-1:0] ID_VAL = 32'h5a3c9617; // arbitrary identification word
	logic core_clk, nrst, tck, tms, tdi, tdo, tdoEn, tmsSampled, chainTestMode, chainIntTest;
	logic chainApplyNow, chainCapture, chainShift, chainShiftIn, chainShiftOut, selValid, selReady;
	logic [6:0] st;
	logic [IR_W-1:0] activeInstr;
	logic [SEL_W-1:0] chainSel, selData;
	logic [7:0] chain_q; // stand-in scan chain
	logic [31:0] o;
	int error_cnt, checks_done;
	int capCnt; // chain capture strobes seen
	jis_probe probe_u (.core_clk, .tdo, .tck, .tms, .tdi, .st);
	jis_chain_select dut_u (.core_clk, .nrst, .tck, .tms, .tdi, .tapCaptureDr(st[0]),
		.tapShiftDr(st[1]), .tapUpdateDr(st[2]), .tapCaptureIr(st[3]), .tapShiftIr(st[4]),
		.tapUpdateIr(st[5]), .tapLogicReset(st[6]), .tapId(ID_VAL), .tdo, .tdoEn, .tmsSampled,
		.activeInstr, .chainSel, .chainTestMode, .chainIntTest, .chainApplyNow, .chainCapture,
		.chainShift, .chainShiftIn, .chainShiftOut, .selValid, .selData, .selReady);
	// chain shifts on the strobe, new bit at the top
	always @(posedge core_clk)
		if (chainShift)
			chain_q <= {chainShiftIn, chain_q[7:1]};
	assign chainShiftOut = chain_q[0];
	// count capture strobes toward the chain
	always @(posedge core_clk)
		if (chainCapture)
			capCnt++;
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic ir(input logic [3:0] c);
		probe_u.scan(3, IR_W, {28'h0, c}, o);
		check("ir capture", o, {28'h0, IR_CAPTURE_VAL});
	endtask
	task automatic t_reset;
		check("instr", activeInstr, INSTR_IDENT);
		check("chain", chainSel, SEL_RESET_CHAIN);
		probe_u.scan(0, ID_W, 32'h0, o);
		check("ident", o, ID_VAL);
	endtask
	// two updates while stalled, then drain
	task automatic t_select;
		ir(INSTR_CHAIN_SEL);
		check("instr", activeInstr, INSTR_CHAIN_SEL);
		probe_u.scan(0, SEL_W, 32'h5, o);
		check("sel capture", o, {27'h0, SEL_CAPTURE_VAL});
		check("chain", chainSel, 5'h05);
		probe_u.scan(0, SEL_W, 32'h1f, o);
		check("chain", chainSel, 5'h1f);
		check("word", selData, 5'h05);
		@(posedge core_clk) selReady <= 1'b1;
		@(posedge core_clk) selReady <= 1'b0;
		@(posedge core_clk);
		check("word", selData, 5'h1f);
		@(posedge core_clk) selReady <= 1'b1;
		@(posedge core_clk) selReady <= 1'b0;
		@(posedge core_clk);
		check("empty", selValid, 1'b0);
	endtask
	task automatic t_bypass(input logic [3:0] c);
		ir(c);
		check("test mode", chainTestMode, 1'b0);
		probe_u.scan(0, 2, 32'h1, o);
		check("bypass", o, 32'h2);
	endtask
	task automatic t_chain(input logic [3:0] c);
		int c0;
		ir(c);
		check("internal", chainIntTest, c == INSTR_INT_TEST);
		check("test mode", chainTestMode, 1'b1);
		@(posedge core_clk) chain_q <= 8'h96;
		c0 = capCnt;
		probe_u.scan(0, 8, 32'h3b, o);
		check("capture", capCnt - c0, 1);
		check("chain out", o, 32'h96);
		check("chain in", chain_q, 8'h3b);
		check("chain", chainSel, 5'h1f);
	endtask
	task automatic t_tlr;
		logic q;
		probe_u.step(7'h40, 1'b0, q);
		check("tms high", tmsSampled, 1'b1);
		check("instr", activeInstr, INSTR_IDENT);
		probe_u.step(7'h0, 1'b1, q);
		check("tms low", tmsSampled, 1'b0);
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		nrst = 1'b0;
		selReady = 1'b0;
		chain_q = 8'h0;
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_reset;
		t_select;
		t_bypass(INSTR_BYPASS);
		t_bypass(4'h5);
		t_chain(INSTR_EXT_TEST);
		t_chain(INSTR_INT_TEST);
		t_tlr;
		close_out;
	end
	// watchdog
	initial
	begin
		#400000;
		error_cnt++;
		close_out;
	end
endmodule
bind jis_chain_select jis_checker chk_u (.core_clk, .nrst, .tck, .tdo, .tdoEn, .tapUpdateDr,
	.activeInstr, .chainSel, .chainTestMode, .chainIntTest, .chainApplyNow, .chainCapture,
	.chainShift, .selValid, .selData, .selReady);
